/* pkg/gpio_port_regs.vh */
// Register offsets, field positions, reset values and bus codes of the GPIO port.
// Included by the port and its bench; holds definitions only.
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// ==========================================================================
// Byte offsets on the AXI4-Lite bus
`define GPIO_OFF_OUTPUT     5'h00
`define GPIO_OFF_DIRECTION  5'h04
`define GPIO_OFF_INPUT      5'h08
`define GPIO_OFF_CONTROL    5'h0c
`define GPIO_OFF_OUT_SET    5'h10
`define GPIO_OFF_OUT_CLR    5'h14
`define GPIO_OFF_DIR_SET    5'h18
`define GPIO_OFF_DIR_CLR    5'h1c

// ==========================================================================
// Fields
`define GPIO_PUD_BIT        6

// ==========================================================================
// Reset values
`define GPIO_RST_PIN_BIT    1'b0
`define GPIO_RST_PUD        1'b0
`define GPIO_RST_OE_N       1'b1

// ==========================================================================
// Bus response codes
`define GPIO_RESP_OKAY      2'b00
`define GPIO_RESP_SLVERR    2'b10

// ==========================================================================
// Timing: the input path delays by one clock period for software-set levels
`define GPIO_SYNC_PERIOD_NS 10

`endif

/* hw/pin_input_sync.v */
// Two-stage pin input synchronizer: falling-edge capture, rising-edge register.
// Assumes the raw pin bus is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pin_input_sync #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] pinRaw,
	output reg  [WIDTH-1:0] pinSync_reg
);

	reg [WIDTH-1:0] capture_reg;

	// ======================================================================
	// Capture stage closes when the clock falls, like a high-transparent latch
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			capture_reg <= {WIDTH{1'b0}};
		end else begin
			capture_reg <= pinRaw;
		end
	end

	// ======================================================================
	// Output stage on the next rising edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pinSync_reg <= {WIDTH{1'b0}};
		end else begin
			pinSync_reg <= capture_reg;
		end
	end

endmodule // pin_input_sync

`default_nettype wire

/* hw/general_digital_io_port.v */
// General-purpose bidirectional I/O port with an AXI4-Lite register slave.
// Assumes the pad ring resolves pinOut, pinOutEnN and pinPullup to the wire,
// and that the sleep controller and interrupt controller share ref_clk.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.vh"

module general_digital_io_port #(
	parameter WIDTH      = 8,
	parameter ADDR_WIDTH = 5
) (
	input  wire                  ref_clk,
	input  wire                  sys_rst,
	// AXI4-Lite slave
	input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire                  s_axi_awvalid,
	output reg                   s_axi_awready,
	input  wire [31:0]           s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output reg                   s_axi_wready,
	output reg  [1:0]            s_axi_bresp,
	output reg                   s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire                  s_axi_arvalid,
	output reg                   s_axi_arready,
	output reg  [31:0]           s_axi_rdata,
	output reg  [1:0]            s_axi_rresp,
	output reg                   s_axi_rvalid,
	input  wire                  s_axi_rready,
	// Sleep and interrupt controllers
	input  wire                  sleepClamp,
	input  wire [WIDTH-1:0]      extIntEnable,
	// Pads
	input  wire [WIDTH-1:0]      pinIn,
	output reg  [WIDTH-1:0]      pinOut,
	output reg  [WIDTH-1:0]      pinOutEnN,
	output reg  [WIDTH-1:0]      pinPullup,
	output wire [WIDTH-1:0]      pinSyncIn
);

	// ======================================================================
	// Helpers
	function [WIDTH-1:0] laneMask;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				laneMask[i] = strb[(i / 8) % 4];
			end
		end
	endfunction

	function [31:0] widen;
		input [WIDTH-1:0] value;
		begin
			widen = 32'h00000000;
			widen[WIDTH-1:0] = value;
		end
	endfunction

	function isMapped;
		input [ADDR_WIDTH-1:0] addr;
		begin
			if (addr == `GPIO_OFF_OUTPUT) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_DIRECTION) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_INPUT) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_CONTROL) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_OUT_SET) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_OUT_CLR) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_DIR_SET) begin
				isMapped = 1'b1;
			end else if (addr == `GPIO_OFF_DIR_CLR) begin
				isMapped = 1'b1;
			end else begin
				isMapped = 1'b0;
			end
		end
	endfunction

	// ======================================================================
	// State
	reg  [WIDTH-1:0]      port_output_reg;
	reg  [WIDTH-1:0]      port_output_next;
	reg  [WIDTH-1:0]      port_direction_reg;
	reg  [WIDTH-1:0]      port_direction_next;
	reg                   global_pullup_disable_reg;
	reg                   global_pullup_disable_next;

	reg                   awHeld_reg;
	reg  [ADDR_WIDTH-1:0] awAddr_reg;
	reg                   wHeld_reg;
	reg  [31:0]           wData_reg;
	reg  [3:0]            wStrb_reg;

	wire                  awTake;
	wire                  wTake;
	wire                  arTake;
	wire                  awHave;
	wire                  wHave;
	wire                  doWrite;
	wire [ADDR_WIDTH-1:0] wrAddr;
	wire [31:0]           wrData;
	wire [WIDTH-1:0]      wrMask;
	wire [WIDTH-1:0]      wrBits;
	wire                  bValidNext;
	wire                  rValidNext;
	wire [WIDTH-1:0]      clampedPin;
	reg  [31:0]           readValue;

	// ======================================================================
	// Input path: clamp ahead of the synchronizer, then two stages
	// Interrupt-enabled pins bypass the clamp; others read low in deep sleep
	assign clampedPin = pinIn & ~({WIDTH{sleepClamp}} & ~extIntEnable);

	pin_input_sync #(
		.WIDTH       (WIDTH)
	) inputSync (
		.clk         (ref_clk),
		.rst         (sys_rst),
		.pinRaw      (clampedPin),
		.pinSync_reg (pinSyncIn)
	);
	// The clamp forces only pins outside extIntEnable low, so the interrupt edge detector
	// on pinSyncIn sees no change on enabled pins at sleep entry and exit.

	// ======================================================================
	// Write channel handshake
	assign awTake  = s_axi_awvalid & s_axi_awready;
	assign wTake   = s_axi_wvalid & s_axi_wready;
	assign awHave  = awHeld_reg | awTake;
	assign wHave   = wHeld_reg | wTake;
	assign doWrite = awHave & wHave & ~s_axi_bvalid;
	assign wrAddr  = awTake ? s_axi_awaddr : awAddr_reg;
	assign wrData  = wTake ? s_axi_wdata : wData_reg;
	assign wrMask  = laneMask(wTake ? s_axi_wstrb : wStrb_reg);
	assign wrBits  = wrData[WIDTH-1:0] & wrMask;

	assign bValidNext = doWrite | (s_axi_bvalid & ~s_axi_bready);

	// ======================================================================
	// Register updates
	always @* begin
		port_output_next           = port_output_reg;
		port_direction_next        = port_direction_reg;
		global_pullup_disable_next = global_pullup_disable_reg;
		if (doWrite) begin
			if (wrAddr == `GPIO_OFF_OUTPUT) begin
				port_output_next = (port_output_reg & ~wrMask) | wrBits;
			end else if (wrAddr == `GPIO_OFF_DIRECTION) begin
				port_direction_next = (port_direction_reg & ~wrMask) | wrBits;
			end else if (wrAddr == `GPIO_OFF_INPUT) begin
				port_output_next = port_output_reg ^ wrBits;
			end else if (wrAddr == `GPIO_OFF_CONTROL) begin
				if (wTake ? s_axi_wstrb[0] : wStrb_reg[0]) begin
					global_pullup_disable_next = wrData[`GPIO_PUD_BIT];
				end
			end else if (wrAddr == `GPIO_OFF_OUT_SET) begin
				port_output_next = port_output_reg | wrBits;
			end else if (wrAddr == `GPIO_OFF_OUT_CLR) begin
				port_output_next = port_output_reg & ~wrBits;
			end else if (wrAddr == `GPIO_OFF_DIR_SET) begin
				port_direction_next = port_direction_reg | wrBits;
			end else if (wrAddr == `GPIO_OFF_DIR_CLR) begin
				port_direction_next = port_direction_reg & ~wrBits;
			end
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_output_reg           <= {WIDTH{`GPIO_RST_PIN_BIT}};
			port_direction_reg        <= {WIDTH{`GPIO_RST_PIN_BIT}};
			global_pullup_disable_reg <= `GPIO_RST_PUD;
		end else begin
			port_output_reg           <= port_output_next;
			port_direction_reg        <= port_direction_next;
			global_pullup_disable_reg <= global_pullup_disable_next;
		end
	end

	// ======================================================================
	// Pad controls, registered from the next register values so the pads
	// follow a write at the same edge that stores it
	// Each pin is computed bitwise, so no pin depends on another
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinOutEnN <= {WIDTH{`GPIO_RST_OE_N}};
			pinOut    <= {WIDTH{`GPIO_RST_PIN_BIT}};
			pinPullup <= {WIDTH{`GPIO_RST_PIN_BIT}};
		end else begin
			pinOutEnN <= ~port_direction_next;
			pinOut    <= port_output_next & port_direction_next;
			pinPullup <= ~port_direction_next & port_output_next
				& {WIDTH{~global_pullup_disable_next}};
		end
	end

	// ======================================================================
	// Write address and data holding
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld_reg    <= 1'b0;
			awAddr_reg    <= {ADDR_WIDTH{1'b0}};
			wHeld_reg     <= 1'b0;
			wData_reg     <= 32'h00000000;
			wStrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `GPIO_RESP_OKAY;
		end else begin
			awHeld_reg    <= awHave & ~doWrite;
			wHeld_reg     <= wHave & ~doWrite;
			if (awTake) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			s_axi_awready <= ~(awHave & ~doWrite) & ~bValidNext;
			s_axi_wready  <= ~(wHave & ~doWrite) & ~bValidNext;
			s_axi_bvalid  <= bValidNext;
			if (doWrite) begin
				s_axi_bresp <= isMapped(wrAddr) ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
			end
		end
	end

	// ======================================================================
	// Read channel
	assign arTake     = s_axi_arvalid & s_axi_arready;
	assign rValidNext = arTake | (s_axi_rvalid & ~s_axi_rready);

	always @* begin
		readValue = 32'h00000000;
		if (s_axi_araddr == `GPIO_OFF_OUTPUT) begin
			readValue = widen(port_output_reg);
		end else if (s_axi_araddr == `GPIO_OFF_DIRECTION) begin
			readValue = widen(port_direction_reg);
		end else if (s_axi_araddr == `GPIO_OFF_INPUT) begin
			readValue = widen(pinSyncIn);
		end else if (s_axi_araddr == `GPIO_OFF_CONTROL) begin
			readValue[`GPIO_PUD_BIT] = global_pullup_disable_reg;
		end else if (s_axi_araddr == `GPIO_OFF_OUT_SET) begin
			readValue = widen(port_output_reg);
		end else if (s_axi_araddr == `GPIO_OFF_OUT_CLR) begin
			readValue = widen(port_output_reg);
		end else if (s_axi_araddr == `GPIO_OFF_DIR_SET) begin
			readValue = widen(port_direction_reg);
		end else if (s_axi_araddr == `GPIO_OFF_DIR_CLR) begin
			readValue = widen(port_direction_reg);
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `GPIO_RESP_OKAY;
		end else begin
			s_axi_arready <= ~rValidNext;
			s_axi_rvalid  <= rValidNext;
			if (arTake) begin
				s_axi_rdata <= readValue;
				s_axi_rresp <= isMapped(s_axi_araddr) ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
			end
		end
	end

endmodule // general_digital_io_port

`default_nettype wire

/* hw/general_digital_io_port_tail.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* bench/gpio_port_sva.sv */
// Checker for the GPIO port, bound to every port instance.
// Assumes pinIn settles away from the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_sva #(
	parameter WIDTH      = 8,
	parameter ADDR_WIDTH = 5
) (
	input wire logic             ref_clk,
	input wire logic             sys_rst,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic             sleepClamp,
	input wire logic [WIDTH-1:0] extIntEnable,
	input wire logic [WIDTH-1:0] pinIn,
	input wire logic [WIDTH-1:0] pinOut,
	input wire logic [WIDTH-1:0] pinOutEnN,
	input wire logic [WIDTH-1:0] pinPullup,
	input wire logic [WIDTH-1:0] pinSyncIn
);
	default clocking @(posedge ref_clk); endclocking
	// ==========================================================================
	// Sequences
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence inQuiet;
		(!sleepClamp && $stable(pinIn))[*2];
	endsequence
	sequence clampQuiet;
		(sleepClamp && $stable(extIntEnable) && $stable(pinIn & extIntEnable))[*3];
	endsequence
	// ==========================================================================
	// Assertions
	rst_hiz_a: assert property (sys_rst |-> pinOutEnN == '1 && pinPullup == '0)
		else $error("pads not released in reset");
	drive_nopull_a: assert property (disable iff (sys_rst) (pinPullup & ~pinOutEnN) == '0)
		else $error("pull-up on a driven pin");
	in_nodrive_a: assert property (disable iff (sys_rst) (pinOut & pinOutEnN) == '0)
		else $error("drive value on an input pin");
	wr_answer_a: assert property (disable iff (sys_rst) wrTaken |=> s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (disable iff (sys_rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rd_answer_a: assert property (disable iff (sys_rst)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	r_hold_a: assert property (disable iff (sys_rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
	sync_lat_a: assert property (disable iff (sys_rst) inQuiet |=> pinSyncIn == $past(pinIn))
		else $error("synchronized pin wrong");
	clamp_gnd_a: assert property (disable iff (sys_rst)
		clampQuiet |=> (pinSyncIn & ~$past(extIntEnable)) == '0)
		else $error("clamped pin not low");
	clamp_skip_a: assert property (disable iff (sys_rst)
		clampQuiet |=> (pinSyncIn & $past(extIntEnable)) == ($past(pinIn) & $past(extIntEnable)))
		else $error("exempt pin clamped");
endmodule // gpio_port_sva

bind general_digital_io_port gpio_port_sva #(.WIDTH(WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) i_gpio_port_sva (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.sleepClamp(sleepClamp), .extIntEnable(extIntEnable), .pinIn(pinIn), .pinOut(pinOut),
	.pinOutEnN(pinOutEnN), .pinPullup(pinPullup), .pinSyncIn(pinSyncIn)
);
`default_nettype wire

/* bench/ext_pin_circuit.sv */
// External circuitry on the pads: a driver on some pins and the wire resolution.
// Assumes pad outputs are registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_circuit #(
	parameter WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] pinOut,
	input  wire logic [WIDTH-1:0] pinOutEnN,
	input  wire logic [WIDTH-1:0] pinPullup,
	input  wire logic [WIDTH-1:0] extDrive,
	input  wire logic [WIDTH-1:0] extDriveEn,
	input  wire logic             clk,
	output logic      [WIDTH-1:0] pinIn
);
	logic [WIDTH-1:0] floatPat = '0;
	// A released line keeps no value
	always @(posedge clk) floatPat <= ~floatPat;
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (!pinOutEnN[i]) pinIn[i] = pinOut[i];
			else if (extDriveEn[i]) pinIn[i] = extDrive[i];
			else if (pinPullup[i]) pinIn[i] = 1'h1;
			else pinIn[i] = floatPat[i];
		end
	end
endmodule // ext_pin_circuit
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the GPIO port through its AXI4-Lite registers.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.vh"
module tb;
	logic ref_clk = 1'h0, sys_rst = 1'h0, sleepClamp = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [4:0] awaddr = 5'h0, araddr = 5'h0;
	logic [31:0] wdata = 32'h0;
	logic [7:0] extIntEnable = 8'h0, extDrive = 8'h40, extDriveEn = 8'hc0;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] pinIn, pinOut, pinOutEnN, pinPullup, pinSyncIn;
	int miscompares = 0, checks = 0, cycles = 0;
	general_digital_io_port i_general_digital_io_port (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sleepClamp(sleepClamp), .extIntEnable(extIntEnable), .pinIn(pinIn), .pinOut(pinOut),
		.pinOutEnN(pinOutEnN), .pinPullup(pinPullup), .pinSyncIn(pinSyncIn));
	ext_pin_circuit i_ext_pin_circuit (.pinOut(pinOut), .pinOutEnN(pinOutEnN),
		.pinPullup(pinPullup), .extDrive(extDrive), .extDriveEn(extDriveEn), .clk(ref_clk),
		.pinIn(pinIn));
	// ==========================================================================
	// Tasks
	task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic aP, wP, aGo, wGo;
		aP = 1'h1;
		wP = 1'h1;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (aP || wP) begin
			@(negedge ref_clk);
			aGo = aP && awready;
			wGo = wP && wready;
			@(posedge ref_clk);
			if (aGo) awvalid <= 1'h0;
			if (wGo) wvalid <= 1'h0;
			aP = aP && !aGo;
			wP = wP && !wGo;
		end
		do @(negedge ref_clk); while (bvalid !== 1'h1);
		check({32'h0, bresp}, {32'h0, `GPIO_RESP_OKAY}, "bresp");
		@(posedge ref_clk);
		bready <= 1'h0;
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [7:0] e, input string what,
		input logic [1:0] er = `GPIO_RESP_OKAY);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge ref_clk); while (arready !== 1'h1);
		@(posedge ref_clk);
		arvalid <= 1'h0;
		do @(negedge ref_clk); while (rvalid !== 1'h1);
		check({rresp, rdata}, {er, 24'h0, e}, what);
		@(posedge ref_clk);
		rready <= 1'h0;
	endtask
	task automatic pins(input logic [7:0] enN, input logic [7:0] pu, input logic [7:0] o);
		@(negedge ref_clk);
		check({10'h0, pinOutEnN, pinPullup, pinOut}, {10'h0, enN, pu, o}, "pads");
	endtask
	// ==========================================================================
	// Clock, watchdog and tests
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		sys_rst <= 1'h1;
		repeat (4) @(posedge ref_clk);
		pins(8'hff, 8'h00, 8'h00);
		@(posedge ref_clk);
		sys_rst <= 1'h0;
		rdChk(`GPIO_OFF_OUTPUT, 8'h00, "out");
		rdChk(`GPIO_OFF_DIRECTION, 8'h00, "dir");
		// Output bits first, so the pin passes through pulled-up input
		wr(`GPIO_OFF_OUTPUT, 8'h3a);
		pins(8'hff, 8'h3a, 8'h00);
		wr(`GPIO_OFF_DIRECTION, 8'h0f);
		pins(8'hf0, 8'h30, 8'h0a);
		rdChk(`GPIO_OFF_INPUT, 8'h7a, "pin");
		wr(`GPIO_OFF_INPUT, 8'h85);
		wr(`GPIO_OFF_INPUT, 8'h00);
		rdChk(`GPIO_OFF_OUTPUT, 8'hbf, "toggle");
		rdChk(`GPIO_OFF_INPUT, 8'h7f, "pin");
		wr(`GPIO_OFF_OUT_CLR, 8'h10);
		wr(`GPIO_OFF_DIR_SET, 8'h20);
		pins(8'hd0, 8'h80, 8'h2f);
		rdChk(`GPIO_OFF_DIRECTION, 8'h2f, "dir");
		wr(`GPIO_OFF_DIR_CLR, 8'h20);
		wr(`GPIO_OFF_OUT_SET, 8'h10);
		rdChk(`GPIO_OFF_OUTPUT, 8'hbf, "out");
		wr(`GPIO_OFF_CONTROL, 8'h40);
		pins(8'hf0, 8'h00, 8'h0f);
		rdChk(`GPIO_OFF_CONTROL, 8'h40, "ctl");
		wr(`GPIO_OFF_CONTROL, 8'h00);
		pins(8'hf0, 8'hb0, 8'h0f);
		@(posedge ref_clk);
		extDrive <= 8'h80;
		@(posedge ref_clk);
		@(negedge ref_clk);
		check({26'h0, pinSyncIn}, {26'h0, 8'hbf}, "sync");
		@(posedge ref_clk);
		extIntEnable <= 8'h81;
		sleepClamp <= 1'h1;
		rdChk(`GPIO_OFF_INPUT, 8'h81, "clamp");
		@(posedge ref_clk);
		sleepClamp <= 1'h0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		check({26'h0, pinSyncIn}, {26'h0, 8'hbf}, "wake");
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		#1 check({18'h0, pinOutEnN, pinPullup}, {18'h0, 16'hff00}, "rst");
		@(posedge ref_clk);
		sys_rst <= 1'h0;
		rdChk(`GPIO_OFF_OUTPUT, 8'h00, "out");
		rdChk(5'h02, 8'h00, "unmapped", `GPIO_RESP_SLVERR);
		stop_test();
	end
endmodule // tb
`default_nettype wire
